// ---- cth_hw_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "cth_defs.svh"

// Overview of operation
// R1: Enable bit lets lasting core undervoltage plus bus silence force sleep.
// R2: Falling edges on the local wake input wake only when enabled.
// R3: Rising edges on the local wake input wake only when enabled.
// R4: After a wake, receive output toggles if enabled, else held low.
// R5: Battery bit clear: inhibit stays on, battery uv and local wake off.
// R6: Battery bit set: inhibit off in sleep, battery uv and local wake on.
// R7: Three-bit code selects dominant transmit timeout, or disables it.
// R8: Upper nibble selects I/O undervoltage time, n times 100 ms.
// R9: Lower nibble selects core undervoltage time, n times 100 ms.
// R10: Undervoltage times may deviate forty percent from nominal.
// R11: Configuration valid bit is set by host after configuring.
// R12: Internal sleep entry wins over host mode requests.
// R13: Reserved bits store and return written value, no effect.
// R14: Unlisted timeout and timer codes are unsupported, act as disabled.
module cth_hw_config_regs #(
  parameter int unsigned UV_STEP_CYCLES =
    32'(64'(`CTH_UV_STEP_MS) * `CTH_CLK_HZ / 1000),
  parameter int unsigned TXTO_1_4_CYCLES =
    32'(`CTH_TXTO_1_4_US * (`CTH_CLK_HZ / 1000000)),
  parameter int unsigned TXTO_2_8_CYCLES =
    32'(`CTH_TXTO_2_8_US * (`CTH_CLK_HZ / 1000000)),
  parameter int unsigned TXTO_5_10_CYCLES =
    32'(`CTH_TXTO_5_10_US * (`CTH_CLK_HZ / 1000000))
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_reg_wr,
  input  wire logic [`CTH_ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  input  wire logic                   i_mode_req_valid,
  input  wire logic                   i_mode_req_sleep,
  input  wire logic                   i_core_uv,
  input  wire logic                   i_io_uv,
  input  wire logic                   i_silence_expired,
  input  wire logic                   i_local_wake,
  input  wire logic                   i_bus_wake_pattern,
  input  wire logic                   i_txd,
  input  wire logic                   i_bus_rx,
  output logic                        o_transmit_timeout_select_bus,
  output logic                        o_rxd,
  output logic                        o_sleep,
  output logic                        o_inhibit_output,
  output logic                        o_battery_undervoltage_detect,
  output logic                        o_local_wake_detect,
  output logic                        o_wake_event,
  output logic                        o_txd_timeout,
  output logic                        o_io_uv_expired,
  output logic                        o_selective_wake_config_valid
);

  localparam int unsigned RXD_TOGGLE_CYCLES =
    `CTH_RXD_TOGGLE_NS / `CTH_CLK_PERIOD_NS;

  logic [7:0] hardware_control_q;
  logic [7:0] txto_ctrl_q;
  logic [7:0] supply_ctrl_q;
  logic [7:0] swk_ctrl1_q;
  logic [7:0] rdata_q;

  cth_pkg::cth_mode_type mode_q;
  logic                  local_wake_prev_q;
  logic                  wake_pending_q;
  logic                  rxd_wake_q;
  logic [5:0]            rxd_div_q;
  logic [`CTH_TXTO_CNT_W-1:0] txto_cnt_q;
  logic                  txto_q;

  logic sleep_uv_en;
  logic lw_fall_en;
  logic lw_rise_en;
  logic wake_toggle_en;
  logic bat_connected;
  logic [2:0] txto_sel;
  logic [`CTH_TXTO_CNT_W-1:0] txto_limit;
  logic txto_enabled;
  logic uv_sleep_entry;
  logic local_wake_hit;
  logic wake_hit;

  cth_uv_if core_uv_bus ();
  cth_uv_if io_uv_bus ();

  assign sleep_uv_en    = hardware_control_q[`CTH_BIT_SLEEP_UV_EN];
  assign lw_fall_en     = hardware_control_q[`CTH_BIT_LW_FALL_EN];
  assign lw_rise_en     = hardware_control_q[`CTH_BIT_LW_RISE_EN];
  assign wake_toggle_en = hardware_control_q[`CTH_BIT_WAKE_TOGGLE];
  assign bat_connected  = hardware_control_q[`CTH_BIT_BAT_CONNECTED];
  assign txto_sel       = txto_ctrl_q[`CTH_TXTO_MSB:`CTH_TXTO_LSB];

  //////////////////////////////////////////////////////////////////////////
  // Register file

  // Whole bytes are stored so reserved bits read back as written
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      hardware_control_q     <= `CTH_RST_HARDWARE_CONTROL;
      txto_ctrl_q   <= `CTH_RST_TXTO_CTRL;
      supply_ctrl_q <= `CTH_RST_SUPPLY_CTRL;
      swk_ctrl1_q   <= `CTH_RST_SWK_CTRL1;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `CTH_OFS_HARDWARE_CONTROL:     hardware_control_q     <= i_reg_wdata; // see R13
        `CTH_OFS_TXTO_CTRL:   txto_ctrl_q   <= i_reg_wdata;
        `CTH_OFS_SUPPLY_CTRL: supply_ctrl_q <= i_reg_wdata;
        `CTH_OFS_SWK_CTRL1:   swk_ctrl1_q   <= i_reg_wdata; // see R11
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      case (i_reg_addr)
        `CTH_OFS_HARDWARE_CONTROL:     rdata_q <= hardware_control_q;
        `CTH_OFS_TXTO_CTRL:   rdata_q <= txto_ctrl_q;
        `CTH_OFS_SUPPLY_CTRL: rdata_q <= supply_ctrl_q;
        `CTH_OFS_SWK_CTRL1:   rdata_q <= swk_ctrl1_q;
        default:              rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_selective_wake_config_valid =
    swk_ctrl1_q[`CTH_BIT_CFG_VALID]; // see R11

  //////////////////////////////////////////////////////////////////////////
  // Supply undervoltage timers

  // Nominal steps sit well inside the forty percent window
  assign core_uv_bus.uv   = i_core_uv;
  assign core_uv_bus.code =
    supply_ctrl_q[`CTH_CORE_UV_MSB:`CTH_CORE_UV_LSB]; // see R9 see R10
  assign io_uv_bus.uv     = i_io_uv;
  assign io_uv_bus.code   =
    supply_ctrl_q[`CTH_IO_UV_MSB:`CTH_IO_UV_LSB]; // see R8 see R10

  cth_uv_timer #(
    .STEP_CYCLES (UV_STEP_CYCLES)
  ) u_core_uv_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .uv_bus    (core_uv_bus)
  );

  cth_uv_timer #(
    .STEP_CYCLES (UV_STEP_CYCLES)
  ) u_io_uv_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .uv_bus    (io_uv_bus)
  );

  assign o_io_uv_expired = io_uv_bus.expired;

  //////////////////////////////////////////////////////////////////////////
  // Operating mode

  assign uv_sleep_entry = sleep_uv_en && core_uv_bus.expired &&
                          i_silence_expired; // see R1

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= cth_pkg::CTH_MODE_NORMAL;
    end else begin
      case (mode_q)
        cth_pkg::CTH_MODE_NORMAL: begin
          // Internal entry is checked first so a host request cannot veto it
          if (uv_sleep_entry) begin
            mode_q <= cth_pkg::CTH_MODE_SLEEP; // see R12
          end else if (i_mode_req_valid && i_mode_req_sleep) begin
            mode_q <= cth_pkg::CTH_MODE_SLEEP;
          end
        end
        cth_pkg::CTH_MODE_SLEEP: begin
          if (i_mode_req_valid && !i_mode_req_sleep) begin
            mode_q <= cth_pkg::CTH_MODE_NORMAL;
          end
        end
        default: mode_q <= cth_pkg::CTH_MODE_NORMAL;
      endcase
    end
  end

  assign o_sleep = (mode_q == cth_pkg::CTH_MODE_SLEEP);
  assign o_inhibit_output = !(o_sleep && bat_connected); // see R5 see R6
  assign o_battery_undervoltage_detect = bat_connected; // see R5 see R6
  assign o_local_wake_detect = bat_connected; // see R5 see R6

  //////////////////////////////////////////////////////////////////////////
  // Wake detection and receive pin signalling

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      local_wake_prev_q <= 1'b1;
    end else begin
      local_wake_prev_q <= i_local_wake;
    end
  end

  assign local_wake_hit = bat_connected &&
    ((lw_fall_en && local_wake_prev_q && !i_local_wake) || // see R2
     (lw_rise_en && !local_wake_prev_q && i_local_wake));  // see R3
  assign wake_hit = o_sleep && (local_wake_hit || i_bus_wake_pattern);
  assign o_wake_event = wake_hit;

  // Pending wake ends only when the host leaves sleep
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !o_sleep) begin
      wake_pending_q <= 1'b0;
    end else if (wake_hit) begin
      wake_pending_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !wake_pending_q) begin
      rxd_div_q  <= 6'h00;
      rxd_wake_q <= 1'b0;
    end else if (wake_toggle_en) begin
      if (rxd_div_q == 6'(RXD_TOGGLE_CYCLES - 1)) begin
        rxd_div_q  <= 6'h00;
        rxd_wake_q <= !rxd_wake_q; // see R4
      end else begin
        rxd_div_q <= rxd_div_q + 6'h01;
      end
    end else begin
      rxd_wake_q <= 1'b0; // see R4
    end
  end

  assign o_rxd = wake_pending_q ? rxd_wake_q :
                 (o_sleep ? 1'b1 : i_bus_rx);

  //////////////////////////////////////////////////////////////////////////
  // Transmit dominant timeout

  always_comb begin
    txto_enabled = 1'b1;
    case (txto_sel)
      `CTH_TXTO_CODE_1_4MS:  txto_limit = `CTH_TXTO_CNT_W'(TXTO_1_4_CYCLES);
      `CTH_TXTO_CODE_2_8MS:  txto_limit = `CTH_TXTO_CNT_W'(TXTO_2_8_CYCLES);
      `CTH_TXTO_CODE_5_10MS: txto_limit = `CTH_TXTO_CNT_W'(TXTO_5_10_CYCLES);
      default: begin
        txto_limit   = '0;
        txto_enabled = 1'b0; // see R7 see R14
      end
    endcase
  end

  // Released by a recessive transmit level, by sleep or by a disabled code, as a stuck pin must not
  // keep the bus dominant
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_txd || o_sleep || !txto_enabled) begin
      txto_cnt_q <= '0;
      txto_q     <= 1'b0;
    end else if (txto_cnt_q == txto_limit - `CTH_TXTO_CNT_W'(1)) begin
      txto_q <= 1'b1; // see R7
    end else begin
      txto_cnt_q <= txto_cnt_q + `CTH_TXTO_CNT_W'(1);
    end
  end

  assign o_txd_timeout = txto_q;
  assign o_transmit_timeout_select_bus  = o_sleep || txto_q || i_txd;

endmodule

`default_nettype wire

// ---- cth_defs.svh ----
`ifndef CTH_DEFS_SVH
`define CTH_DEFS_SVH

// Register offsets
`define CTH_ADDR_W              7
`define CTH_OFS_HARDWARE_CONTROL         7'h02
`define CTH_OFS_TXTO_CTRL       7'h03
`define CTH_OFS_SUPPLY_CTRL     7'h04
`define CTH_OFS_SWK_CTRL1       7'h05

// Reset values
`define CTH_RST_HARDWARE_CONTROL         8'he1
`define CTH_RST_TXTO_CTRL       8'h01
`define CTH_RST_SUPPLY_CTRL     8'hcc
`define CTH_RST_SWK_CTRL1       8'h00

// Field positions
`define CTH_BIT_SLEEP_UV_EN     7
`define CTH_BIT_LW_FALL_EN      6
`define CTH_BIT_LW_RISE_EN      5
`define CTH_BIT_WAKE_TOGGLE     1
`define CTH_BIT_BAT_CONNECTED   0
`define CTH_TXTO_MSB            2
`define CTH_TXTO_LSB            0
`define CTH_IO_UV_MSB           7
`define CTH_IO_UV_LSB           4
`define CTH_CORE_UV_MSB         3
`define CTH_CORE_UV_LSB         0
`define CTH_BIT_CFG_VALID       0

// Transmit timeout codes
`define CTH_TXTO_CODE_1_4MS     3'h1
`define CTH_TXTO_CODE_2_8MS     3'h2
`define CTH_TXTO_CODE_5_10MS    3'h3
`define CTH_TXTO_CODE_OFF       3'h4

// Timing
`define CTH_CLK_HZ              40000000
`define CTH_UV_STEP_MS          100
`define CTH_TXTO_1_4_US         2000
`define CTH_TXTO_2_8_US         4000
`define CTH_TXTO_5_10_US        7000
`define CTH_RXD_TOGGLE_NS       1000
`define CTH_CLK_PERIOD_NS       25
`define CTH_UV_STEP_W           22
`define CTH_TXTO_CNT_W          19

`endif

// ---- cth_pkg.sv ----
`default_nettype none

package cth_pkg;

  typedef enum logic {
    CTH_MODE_NORMAL,
    CTH_MODE_SLEEP
  } cth_mode_type;

  typedef logic [3:0] cth_uv_code_type;

endpackage

`default_nettype wire

// ---- cth_uv_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface cth_uv_if;
  logic                     uv;
  cth_pkg::cth_uv_code_type code;
  logic                     expired;

  modport owner (output uv, output code, input expired);
  modport timer (input uv, input code, output expired);
endinterface

`default_nettype wire

// ---- cth_uv_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "cth_defs.svh"

module cth_uv_timer #(
  parameter int unsigned STEP_CYCLES = 4000000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  cth_uv_if.timer   uv_bus
);

  localparam logic [`CTH_UV_STEP_W-1:0] STEP_LAST =
    `CTH_UV_STEP_W'(STEP_CYCLES - 1);

  logic [`CTH_UV_STEP_W-1:0] step_cnt_q;
  logic [3:0]                steps_q;

  // Whole 100 ms steps are counted so no wide multiply is needed
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !uv_bus.uv) begin
      step_cnt_q <= '0;
      steps_q    <= 4'h0;
    end else if (steps_q != uv_bus.code) begin
      if (step_cnt_q == STEP_LAST) begin
        step_cnt_q <= '0;
        steps_q    <= steps_q + 4'h1;
      end else begin
        step_cnt_q <= step_cnt_q + `CTH_UV_STEP_W'(1);
      end
    end
  end

  // Code zero is unsupported and never expires
  assign uv_bus.expired = uv_bus.uv && (uv_bus.code != 4'h0) &&
                          (steps_q == uv_bus.code); // see R8 see R14

endmodule

`default_nettype wire

// ---- cth_hw_config_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module cth_hw_config_chk #(
  parameter int unsigned UV_STEP_CYCLES  = 10,
  parameter int unsigned TXTO_1_4_CYCLES = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_mode_req_valid,
  input wire logic i_core_uv,
  input wire logic i_io_uv,
  input wire logic i_local_wake,
  input wire logic i_bus_wake_pattern,
  input wire logic i_txd,
  input wire logic o_transmit_timeout_select_bus,
  input wire logic o_sleep,
  input wire logic o_inhibit_output,
  input wire logic o_battery_undervoltage_detect,
  input wire logic o_wake_event,
  input wire logic o_txd_timeout,
  input wire logic o_io_uv_expired
);
  int unsigned io_cnt_q;
  int unsigned low_cnt_q;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Run lengths of the causes, so expiry can be tied to a real count
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_io_uv) io_cnt_q <= 0;
    else io_cnt_q <= io_cnt_q + 1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || i_txd || o_sleep) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_q + 1;
  end
  inhibit_level_a: assert property (
    o_inhibit_output == !(o_sleep && o_battery_undervoltage_detect))
    else $error("inhibit level wrong");
  sleep_cause_a: assert property (
    $rose(o_sleep) |-> $past(i_mode_req_valid) ||
      $past(i_mode_req_valid, 2) || $past(i_core_uv))
    else $error("sleep entered without cause");
  local_wake_a: assert property (
    o_wake_event && !i_bus_wake_pattern |-> o_sleep &&
      o_battery_undervoltage_detect && i_local_wake != $past(i_local_wake))
    else $error("wake event without enabled local edge");
  txd_pass_a: assert property (
    o_transmit_timeout_select_bus == (o_sleep || o_txd_timeout || i_txd))
    else $error("transmit path wrong");
  txd_release_a: assert property (
    o_txd_timeout && i_txd |=> !o_txd_timeout)
    else $error("timeout not cleared by recessive input");
  txd_limit_a: assert property (
    $rose(o_txd_timeout) |-> low_cnt_q >= TXTO_1_4_CYCLES - 1)
    else $error("timeout came too early");
  io_uv_count_a: assert property (
    $rose(o_io_uv_expired) |-> io_cnt_q >= UV_STEP_CYCLES - 1)
    else $error("io undervoltage expired too early");
  io_uv_drop_a: assert property (
    o_io_uv_expired && !i_io_uv |=> !o_io_uv_expired)
    else $error("io undervoltage expiry outlived cause");
  cover property (o_wake_event);
  cover property ($rose(o_txd_timeout));
  cover property ($rose(o_io_uv_expired));
  cover property (o_wake_event && i_bus_wake_pattern);
endmodule

bind cth_hw_config_regs cth_hw_config_chk #(
  .UV_STEP_CYCLES(UV_STEP_CYCLES), .TXTO_1_4_CYCLES(TXTO_1_4_CYCLES)
) cth_hw_config_chk_inst (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_mode_req_valid(i_mode_req_valid), .i_core_uv(i_core_uv),
  .i_io_uv(i_io_uv), .i_local_wake(i_local_wake),
  .i_bus_wake_pattern(i_bus_wake_pattern), .i_txd(i_txd),
  .o_transmit_timeout_select_bus(o_transmit_timeout_select_bus), .o_sleep(o_sleep),
  .o_inhibit_output(o_inhibit_output),
  .o_battery_undervoltage_detect(o_battery_undervoltage_detect),
  .o_wake_event(o_wake_event), .o_txd_timeout(o_txd_timeout),
  .o_io_uv_expired(o_io_uv_expired));
`default_nettype wire

// ---- cth_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cth_defs.svh"
module cth_host_model (
  input  wire logic                   i_sys_clk,
  output logic                        o_wr,
  output logic      [`CTH_ADDR_W-1:0] o_addr,
  output logic      [7:0]             o_wdata,
  input  wire logic [7:0]             i_rdata
);
  initial begin
    o_wr = 1'b0;
    o_addr = '0;
    o_wdata = 8'h00;
  end
  // Data is inverted once released, so a stale byte is never mistaken
  task automatic wr(input logic [`CTH_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #2;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #2;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [`CTH_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #2;
    o_addr = a;
    @(posedge i_sys_clk);
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- can_transceiver_hw_config_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cth_defs.svh"
module can_transceiver_hw_config_regs_bench;
  localparam int STEP = 10;
  logic                   clk = 0, rst_n = 0, mreq = 0, msl = 0, cuv = 0;
  logic                   iouv = 0, sil = 0, lw = 1, txd = 1, brx = 0;
  logic                   wr, tob, rxd, slp, inhibit_output, buv, lwd, wev, tto, ioe;
  logic                   cfg, bwp = 0;
  logic [`CTH_ADDR_W-1:0] addr;
  logic [7:0]             wdata, rdata;
  logic [7:0]             m [4] = '{`CTH_RST_HARDWARE_CONTROL, `CTH_RST_TXTO_CTRL,
                                    `CTH_RST_SUPPLY_CTRL, `CTH_RST_SWK_CTRL1};
  int                     n_errors = 0, checked = 0;
  always #12.5 clk = ~clk;
  cth_hw_config_regs #(.UV_STEP_CYCLES(STEP), .TXTO_1_4_CYCLES(8),
    .TXTO_2_8_CYCLES(16), .TXTO_5_10_CYCLES(28)) cth_hw_config_regs_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_mode_req_valid(mreq),
    .i_mode_req_sleep(msl), .i_core_uv(cuv), .i_io_uv(iouv),
    .i_silence_expired(sil), .i_local_wake(lw), .i_bus_wake_pattern(bwp),
    .i_txd(txd), .i_bus_rx(brx), .o_transmit_timeout_select_bus(tob), .o_rxd(rxd),
    .o_sleep(slp), .o_inhibit_output(inhibit_output),
    .o_battery_undervoltage_detect(buv), .o_local_wake_detect(lwd),
    .o_wake_event(wev), .o_txd_timeout(tto), .o_io_uv_expired(ioe),
    .o_selective_wake_config_valid(cfg));
  cth_host_model cth_host_model_inst (.i_sys_clk(clk), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Inputs always move 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic mode(input logic s);
    mreq = 1;
    msl = s;
    cyc(1);
    mreq = 0;
    cyc(1);
  endtask
  initial begin
    logic [7:0] d;
    int lim, w, s0, s1;
    void'($urandom(21));
    cyc(6);
    rst_n = 1;
    // Reset values first, then random bytes; addresses 1 and 6 are unmapped
    for (int p = 0; p < 4; p++) begin
      for (int a = 1; a < 7 && p > 0; a++) begin
        d = 8'($urandom);
        cth_host_model_inst.wr(7'(a), d);
        if (a > 1 && a < 6) m[a-2] = d;
      end
      for (int a = 1; a < 7; a++) begin
        cth_host_model_inst.rd(7'(a), d);
        chk(d, (a > 1 && a < 6) ? m[a-2] : 8'h00);
      end
      chk({7'h00, cfg}, {7'h00, m[3][0]});
    end
    for (int c = 0; c < 8; c++) begin
      cth_host_model_inst.wr(7'h03, {5'($urandom), 3'(c)});
      lim = (c == 1) ? 8 : (c == 2) ? 16 : (c == 3) ? 28 : 0;
      brx = 1'($urandom);
      txd = 0;
      cyc((lim > 0) ? lim - 2 : 40);
      chk({6'h00, tto, tob}, 8'h00);
      chk({7'h00, rxd}, {7'h00, brx});
      cyc(4);
      chk({6'h00, tto, tob}, (lim > 0) ? 8'h03 : 8'h00);
      txd = 1;
      cyc(1);
      chk({6'h00, tto, tob}, 8'h01);
    end
    // Windows are the nominal time widened by forty percent either way
    for (int n = 0; n < 4; n++) begin
      cth_host_model_inst.wr(7'h04, {4'(n), 4'h0});
      iouv = 1;
      cyc((n > 0) ? n * STEP * 6 / 10 - 1 : 40);
      chk({7'h00, ioe}, 8'h00);
      cyc(n * STEP * 8 / 10 + 3);
      chk({7'h00, ioe}, {7'h00, n > 0});
      iouv = 0;
      cyc(2);
      chk({7'h00, ioe}, 8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      cth_host_model_inst.wr(7'h02, {1'(b), 7'h01});
      cth_host_model_inst.wr(7'h04, 8'h02);
      cuv = 1;
      sil = 1;
      cyc(STEP * 2 * 6 / 10 - 1);
      chk({7'h00, slp}, 8'h00);
      cyc(STEP * 2 * 8 / 10 + 3);
      chk({7'h00, slp}, {7'h00, 1'(b)});
      cuv = 0;
      sil = 0;
      mode(0);
    end
    for (int c = 0; c < 16; c++) begin
      d = {1'b0, c[2], c[1], 3'h0, c[3], c[0]};
      cth_host_model_inst.wr(7'h02, d);
      mode(1);
      chk({6'h00, slp, inhibit_output}, {6'h00, 1'b1, !d[0]});
      chk({6'h00, buv, lwd}, {6'h00, d[0], d[0]});
      lw = 0;
      #1 chk({7'h00, wev}, {7'h00, d[0] & d[6]});
      cyc(1);
      lw = 1;
      #1 chk({7'h00, wev}, {7'h00, d[0] & d[5]});
      s0 = 0;
      s1 = 0;
      repeat (100) begin
        cyc(1);
        if (rxd === 1'b0) s0++;
        if (rxd === 1'b1) s1++;
      end
      w = d[0] & (d[6] | d[5]);
      chk({7'h00, s0 > 0}, 8'(w));
      chk({7'h00, s1 > 0}, {7'h00, w == 0 || d[1]});
      mode(0);
    end
    // A bus wake pattern wakes even with the battery bit clear
    cth_host_model_inst.wr(7'h02, 8'h00);
    mode(1);
    bwp = 1;
    #1 chk({7'h00, wev}, 8'h01);
    cyc(1);
    bwp = 0;
    cyc(3);
    chk({7'h00, rxd}, 8'h00);
    mode(0);
    summarize;
  end
  // The sequence needs about 2300 cycles
  initial begin
    cyc(20000);
    n_errors++;
    summarize;
  end
endmodule
`default_nettype wire
